// [common/sdram_bank_map.vh]
// Operation
// R1: chip select high is inhibit; all strobes high is nop; both keep operations running
// R2: idle bank decodes row strobe low alone as activate, opening a row
// R3: refresh and mode load are device wide; controller issues them with all banks idle
// R4: precharge to an idle bank leaves it idle, acting as nop
// R5: row active bank decodes column strobe low as read, or write with write enable
// R6: read or write during plain burst restarts burst at the new column
// R7: precharge during plain burst cuts the burst and starts precharging
// R8: burst terminate stops the most recently registered burst, whatever its bank
// R9: decoding applies only while clock enable was and is high
// R10: bank is idle only after precharge and full row precharge time
// R11: bank is row active after activate plus activate-to-column delay, no burst
// R12: controller sends nothing to a bank in a timed transient state
// R13: precharging starts on precharge and ends at row precharge time, then idle
// R14: row activating starts on activate, ends at activate delay, then row active
// R15: read or write with auto precharge holds bank until precharge time, then idle
// R16: controller sends only inhibit or nop during refresh, mode load, precharge all
// R17: refreshing lasts refresh cycle time, then all banks idle
// R18: mode register access lasts mode set delay, then all banks idle
// R19: precharge all lasts row precharge time, then all banks idle
// R20: controller ensures every bank may precharge before precharge all
// R21: commands to other banks stay accepted while one bank is busy
// R22: controller never issues unsupported state and command pairs
// R23: address bit ten enables auto precharge on read or write; bank bits select
// R24: precharge with bit ten low hits one bank, high hits all banks
// R25: timing windows are cycle count parameters, one countdown per bank plus device
`ifndef SDRAM_BANK_MAP_VH
`define SDRAM_BANK_MAP_VH
// bank states
`define BST_IDLE     3'h0
`define BST_ACTING   3'h1
`define BST_ACTIVE   3'h2
`define BST_READ     3'h3
`define BST_WRITE    3'h4
`define BST_READ_AP  3'h5
`define BST_WRITE_AP 3'h6
`define BST_PRECH    3'h7
// device states
`define DST_NORMAL   2'h0
`define DST_REFRESH  2'h1
`define DST_MODE     2'h2
`define DST_PREALL   2'h3
// command codes {ras_n,cas_n,we_n}
`define CMD_ACT      3'h3
`define CMD_REF      3'h1
`define CMD_LMR      3'h0
`define CMD_PRE      3'h2
`define CMD_RD       3'h5
`define CMD_WR       3'h4
`define CMD_BST      3'h6
`define CMD_NOP      3'h7
// default timing counts in cycles
`define T_RP_CYC     8'h03
`define T_RCD_CYC    8'h03
`define T_RFC_CYC    8'h04
`define T_MRD_CYC    8'h02
`define CNT_ZERO     8'h00
`define CNT_ONE      8'h01
`endif

// [dv/sdram_bank_fsm_sva.sv]
`timescale 1ns/10ps
`include "sdram_bank_map.vh"
module sdram_bank_fsm_sva #(
	parameter [7:0] T_RP  = 8'h03,
	parameter [7:0] T_RCD = 8'h03,
	parameter [7:0] T_RFC = 8'h04,
	parameter [7:0] T_MRD = 8'h02
) (
	// clock and reset
	input wire        ref_clk,
	input wire        srst,
	// command pins
	input wire        cke,
	input wire        cs_n,
	input wire        ras_n,
	input wire        cas_n,
	input wire        we_n,
	input wire        a10,
	input wire [1:0]  ba,
	// state
	input wire [11:0] bank_state,
	input wire [1:0]  dev_state,
	input wire        burst_live,
	input wire [1:0]  burst_bank,
	input wire        cmd_illegal
);
	localparam int RP = T_RP, RP1 = T_RP - 1, RCD = T_RCD, RCD1 = T_RCD - 1;
	localparam int RFC = T_RFC, RFC1 = T_RFC - 1, MRD = T_MRD, MRD1 = T_MRD - 1;
	// state moves two sampled edges after the pins, past the sync stages
	wire [2:0] c   = {ras_n, cas_n, we_n};
	wire [2:0] b0  = bank_state[2:0];
	wire       go  = !cs_n && cke;
	wire       act0 = go && c == `CMD_ACT && ba == 2'h0;
	wire       pall = go && c == `CMD_PRE && a10;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	property p_rcd; $rose(b0 == 3'h1) |-> ##[RCD1:RCD] b0 == 3'h2; endproperty
	a_rcd: assert property (p_rcd) else $error("activate delay wrong");
	property p_rp; $rose(b0 == 3'h7) |-> ##[RP1:RP] b0 == 3'h0; endproperty
	a_rp: assert property (p_rp) else $error("precharge time wrong");
	property p_ap; $rose(b0 == 3'h5 || b0 == 3'h6) |-> ##[RP1:RP] b0 == 3'h0;
	endproperty
	a_ap: assert property (p_ap) else $error("auto precharge wrong");
	property p_rfc; $rose(dev_state == 2'h1) |-> ##[RFC1:RFC] dev_state == 2'h0;
	endproperty
	a_rfc: assert property (p_rfc) else $error("refresh time wrong");
	property p_mrd; $rose(dev_state == 2'h2) |-> ##[MRD1:MRD] dev_state == 2'h0;
	endproperty
	a_mrd: assert property (p_mrd) else $error("mode delay wrong");
	property p_pall; $rose(dev_state == 2'h3) |-> bank_state == 12'hFFF
		##[RP1:RP] bank_state == 12'h000; endproperty
	a_pall: assert property (p_pall) else $error("precharge all wrong");
	// an idle bank only moves on activate or precharge all
	property p_hold; b0 == 3'h0 && !$past(act0 || pall, 2) |=> b0 == 3'h0;
	endproperty
	a_hold: assert property (p_hold) else $error("idle bank moved");
	property p_act; $past(act0, 2) && $past(cke, 3) && b0 == 3'h0 &&
		dev_state == 2'h0 |=> b0 == 3'h1; endproperty
	a_act: assert property (p_act) else $error("activate not taken");
	property p_bst; $past(go && c == `CMD_BST, 2) && $past(cke, 3) &&
		burst_live && burst_bank == 2'h0 && (b0 == 3'h3 || b0 == 3'h4)
		|=> b0 == 3'h2;
	endproperty
	a_bst: assert property (p_bst) else $error("terminate missed");
	property p_ill; $past(act0, 2) && $past(cke, 3) && b0 == 3'h1
		|-> ##[1:2] cmd_illegal;
	endproperty
	a_ill: assert property (p_ill) else $error("busy bank not flagged");
	c_act: cover property ($rose(b0 == 3'h1));
	c_pall: cover property ($rose(dev_state == 2'h3));
	c_ill: cover property (cmd_illegal);
endmodule // sdram_bank_fsm_sva
bind sdram_bank_fsm sdram_bank_fsm_sva #(.T_RP(T_RP), .T_RCD(T_RCD),
	.T_RFC(T_RFC), .T_MRD(T_MRD)) chk (.ref_clk(ref_clk), .srst(srst),
	.cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
	.a10(a10), .ba(ba), .bank_state(bank_state), .dev_state(dev_state),
	.burst_live(burst_live), .burst_bank(burst_bank), .cmd_illegal(cmd_illegal));

// [dv/sdram_ctrl_model.sv]
`timescale 1ns/10ps
`include "sdram_bank_map.vh"
module sdram_ctrl_model (
	// clock
	input  wire       ref_clk,
	// command bus
	output reg        cke,
	output reg        cs_n,
	output reg        ras_n,
	output reg        cas_n,
	output reg        we_n,
	output reg        a10,
	output reg  [1:0] ba
);
	// bus starts as nop so nothing is decoded during reset
	initial begin
		{cke, cs_n, ras_n, cas_n, we_n, a10, ba} = {2'h2, `CMD_NOP, 3'h0};
	end
	// one command per call, then nop; address scrambled as it is dont care
	task cmd(input k, input c_n, input [2:0] c, input a, input [1:0] b);
		@(posedge ref_clk);
		#1 {cke, cs_n, ras_n, cas_n, we_n, a10, ba} = {k, c_n, c, a, b};
		@(posedge ref_clk);
		#1 {cke, cs_n, ras_n, cas_n, we_n, a10, ba} = {2'h2, `CMD_NOP, ~a, ~b};
	endtask
endmodule // sdram_ctrl_model

// [dv/tb_top.sv]
`timescale 1ns/10ps
`include "sdram_bank_map.vh"
module tb_top;
	reg          ref_clk = 1'h0;
	reg          srst = 1'h1;
	wire         cke, cs_n, ras_n, cas_n, we_n, a10, all_idle;
	wire         burst_live, cmd_illegal;
	wire [1:0]   ba, dev_state, burst_bank;
	wire [11:0]  bank_state;
	reg  [1:0]   dv;
	reg  [11:0]  st;
	reg  [13:0]  last;
	logic [13:0] exp_q[$];
	int          failures = 0, num_checks = 0, n_ill = 0, exp_ill = 0, b, i;

	sdram_bank_fsm DUT (.ref_clk(ref_clk), .srst(srst), .cke(cke), .cs_n(cs_n),
		.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .a10(a10), .ba(ba),
		.bank_state(bank_state), .dev_state(dev_state), .all_idle(all_idle),
		.burst_live(burst_live), .burst_bank(burst_bank),
		.cmd_illegal(cmd_illegal));
	sdram_ctrl_model ctl (.ref_clk(ref_clk), .cke(cke), .cs_n(cs_n),
		.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .a10(a10), .ba(ba));

	task check(input logic [13:0] got, input logic [13:0] want);
		num_checks++;
		if (got !== want) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask
	task finish_test;
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// note the next state snapshot; bank 4 stands for every bank
	task note(input [1:0] d, input int k, input [2:0] s);
		dv = d;
		if (k < 4) st[3*k +: 3] = s;
		else st = {4{s}};
		exp_q.push_back({dv, st});
	endtask
	task go(input [2:0] c, input a, input [1:0] bk);
		ctl.cmd(1'h1, 1'h0, c, a, bk);
	endtask
	// bounded wait until every note is matched, then the idle flag
	task drain;
		for (int n = 0; n < 40 && exp_q.size() != 0; n++) @(posedge ref_clk);
		repeat (6) @(posedge ref_clk);
		check(14'(exp_q.size()), 14'h0000);
		check(all_idle, st == 12'h000 && dv == 2'h0);
	endtask

	initial forever #10 ref_clk = ~ref_clk;
	// hang guard, far beyond the few hundred cycles the run needs
	initial begin
		#400000;
		failures++;
		finish_test;
	end
	// every state change must match the oldest note; an unnoted change fails unless it lands on 3FFF, the precharge all state
	always @(posedge ref_clk) begin
		#2;
		if (srst) last = 14'h0000;
		else if ({dev_state, bank_state} !== last) begin
			last = {dev_state, bank_state};
			check(last, exp_q.size() ? exp_q.pop_front() : 14'h3FFF);
		end
		if (cmd_illegal === 1'h1) n_ill++;
	end
	initial begin
		void'($urandom(32'hB8E8));
		st = 12'h000;
		dv = 2'h0;
		repeat (16) @(posedge ref_clk);
		#1 srst = 1'h0;
		// deselected or clock-disabled commands move nothing
		repeat (8) begin
			ctl.cmd(1'h1, 1'h1, 3'($urandom), 1'h0, 2'($urandom));
			ctl.cmd(1'h0, 1'h0, `CMD_ACT, 1'h0, 2'($urandom));
		end
		drain;
		for (i = 0; i < 2; i++) begin
			b = i ? 1 + $urandom % 3 : 0;
			// open a row; a second activate while opening is refused
			go(`CMD_ACT, 1'h0, b[1:0]);
			note(0, b, 1);
			note(0, b, 2);
			go(`CMD_ACT, 1'h0, b[1:0]);
			exp_ill++;
			drain;
			// bursts restart, terminate ignores bank, precharge cuts burst
			go(`CMD_RD, 1'h0, b[1:0]);
			note(0, b, 3);
			go(`CMD_WR, 1'h0, b[1:0]);
			note(0, b, 4);
			go(`CMD_BST, 1'h0, ~b[1:0]);
			note(0, b, 2);
			go(`CMD_RD, 1'h0, b[1:0]);
			note(0, b, 3);
			go(`CMD_PRE, 1'h0, b[1:0]);
			note(0, b, 7);
			note(0, b, 0);
			drain;
			check(burst_live, 1'h0);
			go(`CMD_PRE, 1'h0, b[1:0]);
			drain;
			// other bank opens beside an active one; then auto precharge
			go(`CMD_ACT, 1'h0, b[1:0]);
			note(0, b, 1);
			note(0, b, 2);
			drain;
			go(`CMD_ACT, 1'h0, b[1:0] ^ 2'h1);
			note(0, b ^ 1, 1);
			note(0, b ^ 1, 2);
			drain;
			go(`CMD_WR, 1'h1, b[1:0]);
			note(0, b, 6);
			note(0, b, 0);
			drain;
			check({burst_live, burst_bank}, {1'h1, b[1:0]});
			// device-wide operations, issued only with legal bank states
			go(`CMD_PRE, 1'h1, b[1:0]);
			note(3, 4, 7);
			note(0, 4, 0);
			drain;
			check(burst_live, 1'h0);
			go(`CMD_REF, 1'h0, b[1:0]);
			note(1, 4, 0);
			note(0, 4, 0);
			drain;
			go(`CMD_LMR, 1'h0, b[1:0]);
			note(2, 4, 0);
			note(0, 4, 0);
			drain;
		end
		check(14'(n_ill), 14'(exp_ill));
		finish_test;
	end
endmodule // tb_top

// [verilog/bank_countdown.v]
`timescale 1ns/10ps
`include "sdram_bank_map.vh"
// loadable down counter; done pulses as the count expires
module bank_countdown #(
	parameter W = 8
) (
	// clock and reset
	input  wire         ref_clk,
	input  wire         srst,
	// control
	input  wire         load,
	input  wire [W-1:0] load_val,
	// status
	output wire         running,
	output wire         done
);
	reg [W-1:0] cnt_q;

	// load wins over counting so a restart is never lost
	always @(posedge ref_clk) begin
		if (srst)
			cnt_q <= {W{1'b0}};
		else if (load)
			cnt_q <= load_val;
		else if (cnt_q != {W{1'b0}})
			cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
	end

	assign running = (cnt_q != {W{1'b0}});
	assign done    = (cnt_q == {{(W-1){1'b0}}, 1'b1}) && !load;
endmodule // bank_countdown

// [verilog/sdram_bank_fsm.v]
`timescale 1ns/10ps
`include "sdram_bank_map.vh"
// command decoder and per-bank state tracker
module sdram_bank_fsm #(
	parameter       NB    = 4,
	parameter       BAW   = 2,
	parameter [7:0] T_RP  = `T_RP_CYC,
	parameter [7:0] T_RCD = `T_RCD_CYC,
	parameter [7:0] T_RFC = `T_RFC_CYC,
	parameter [7:0] T_MRD = `T_MRD_CYC
) (
	// clock and reset
	input  wire            ref_clk,
	input  wire            srst,
	// command pins, sampled as async inputs
	input  wire            cke,
	input  wire            cs_n,
	input  wire            ras_n,
	input  wire            cas_n,
	input  wire            we_n,
	input  wire            a10,
	input  wire [BAW-1:0]  ba,
	// state outputs
	output reg  [3*NB-1:0] bank_state,
	output reg  [1:0]      dev_state,
	output reg             all_idle,
	output reg             burst_live,
	output reg  [BAW-1:0]  burst_bank,
	output reg             cmd_illegal
);
	// two stage synchronisers on all pins; costs two cycles of latency
	reg [7+BAW-1:0] s1_q;
	reg [7+BAW-1:0] s2_q;
	reg             cke_prev_q;

	// first stage; only the second stage may read it
	always @(posedge ref_clk) begin
		if (srst)
			s1_q <= {(7+BAW){1'b0}};
		else
			s1_q <= {cke, cs_n, ras_n, cas_n, we_n, a10, 1'b0, ba};
	end

	// second stage feeds the decoder
	always @(posedge ref_clk) begin
		if (srst)
			s2_q <= {(7+BAW){1'b0}};
		else
			s2_q <= s1_q;
	end

	// clock enable one edge back, for the two-edge gate [R9]
	always @(posedge ref_clk) begin
		if (srst)
			cke_prev_q <= 1'b0;
		else
			cke_prev_q <= s2_q[6+BAW];
	end

	wire           p_cke  = s2_q[6+BAW];
	wire           p_cs_n = s2_q[5+BAW];
	wire [2:0]     p_cmd  = s2_q[4+BAW:2+BAW];
	wire           p_a10  = s2_q[1+BAW];
	wire [BAW-1:0] p_ba   = s2_q[BAW-1:0];

	// decode is gated by clock enable on both edges [R9]
	wire valid = p_cke && cke_prev_q && !p_cs_n; // inhibit drops [R1]
	reg  is_act;
	reg  is_ref;
	reg  is_lmr;
	reg  is_pre;
	reg  is_rd;
	reg  is_wr;
	reg  is_bst;

	// one strobe per command; nop raises none [R1]
	always @* begin
		is_act = 1'b0;
		is_ref = 1'b0;
		is_lmr = 1'b0;
		is_pre = 1'b0;
		is_rd  = 1'b0;
		is_wr  = 1'b0;
		is_bst = 1'b0;
		if (valid) begin
			case (p_cmd)
			`CMD_ACT: is_act = 1'b1;
			`CMD_REF: is_ref = 1'b1;
			`CMD_LMR: is_lmr = 1'b1;
			`CMD_PRE: is_pre = 1'b1;
			`CMD_RD:  is_rd  = 1'b1;
			`CMD_WR:  is_wr  = 1'b1;
			`CMD_BST: is_bst = 1'b1;
			default:  is_act = 1'b0; // nop keeps work running
			endcase
		end
	end

	// device and bank state
	reg [1:0]     dst_q;
	reg [1:0]     dst_d;
	reg [2:0]     st_q [0:NB-1];
	reg [2:0]     st_x [0:NB-1];
	reg [2:0]     st_d [0:NB-1];

	// countdown controls
	reg [NB-1:0]  ld;
	reg [7:0]     ldv [0:NB-1];
	wire [NB-1:0] b_done;
	reg           dld;
	reg [7:0]     dldv;
	wire          d_done;

	// burst bookkeeping and flags
	reg           bl_q;
	reg           bl_d;
	reg [BAW-1:0] bb_q;
	reg [BAW-1:0] bb_d;
	reg           ill_d;
	reg           idle_all;
	reg           idle_nx;

	// loop indices, one per process
	integer       i;
	integer       e;
	integer       j;
	integer       k;
	integer       m;

	// one countdown per bank [R25]
	genvar g;
	generate
		for (g = 0; g < NB; g = g + 1) begin : g_bank
			bank_countdown #(.W(8)) u_cnt (
				.ref_clk  (ref_clk),
				.srst     (srst),
				.load     (ld[g]),
				.load_val (ldv[g]),
				.running  (),
				.done     (b_done[g])
			);
		end
	endgenerate

	// device wide countdown [R25]
	bank_countdown #(.W(8)) u_dev (
		.ref_clk  (ref_clk),
		.srst     (srst),
		.load     (dld),
		.load_val (dldv),
		.running  (),
		.done     (d_done)
	);

	// timed states fall back once their countdown expires
	always @* begin
		for (e = 0; e < NB; e = e + 1) begin
			st_x[e] = st_q[e];
			if (b_done[e]) begin
				case (st_q[e])
				`BST_ACTING:   st_x[e] = `BST_ACTIVE; // [R14] [R11]
				`BST_PRECH:    st_x[e] = `BST_IDLE;   // [R13] [R10]
				`BST_READ_AP,
				`BST_WRITE_AP: st_x[e] = `BST_IDLE;   // [R15]
				default:       st_x[e] = st_q[e];
				endcase
			end
		end
	end

	// next state; timed states expire first, but the command is decoded against the state before expiry
	always @* begin
		dst_d = dst_q;
		bl_d  = bl_q;
		bb_d  = bb_q;
		dld   = 1'b0;
		dldv  = `CNT_ZERO;
		ill_d = 1'b0;
		idle_all = 1'b1;
		for (i = 0; i < NB; i = i + 1) begin
			st_d[i] = st_q[i];
			ld[i]   = 1'b0;
			ldv[i]  = `CNT_ZERO;
			if (st_q[i] != `BST_IDLE)
				idle_all = 1'b0;
		end
		case (dst_q)
		`DST_NORMAL: begin
			// expired timed states first [R13] [R14] [R15]
			for (i = 0; i < NB; i = i + 1)
				st_d[i] = st_x[i];
			if (is_ref || is_lmr) begin
				// device wide; only legal with every bank idle [R3]
				if (!idle_all)
					ill_d = 1'b1;
				dld   = 1'b1;
				bl_d  = 1'b0;
				if (is_ref) begin
					dst_d = `DST_REFRESH; // [R17]
					dldv  = T_RFC;
				end else begin
					dst_d = `DST_MODE; // [R18]
					dldv  = T_MRD;
				end
			end else if (is_pre && p_a10) begin
				// precharge all ignores the bank bits [R24] [R19]
				dst_d = `DST_PREALL;
				dld   = 1'b1;
				dldv  = T_RP;
				bl_d  = 1'b0;
				for (i = 0; i < NB; i = i + 1)
					st_d[i] = `BST_PRECH;
			end else if (is_bst) begin
				// stop the last burst, any bank [R8]
				if (bl_q && (st_q[bb_q] == `BST_READ ||
				    st_q[bb_q] == `BST_WRITE))
					st_d[bb_q] = `BST_ACTIVE;
				bl_d = 1'b0;
			end else if (is_act || is_pre || is_rd || is_wr) begin
				// other banks keep running meanwhile [R21]
				case (st_q[p_ba])
				`BST_IDLE: begin
					if (is_act) begin
						st_d[p_ba] = `BST_ACTING; // [R2] [R14]
						ld[p_ba]   = 1'b1;
						ldv[p_ba]  = T_RCD;
					end else if (!is_pre)
						ill_d = 1'b1; // precharge stays idle [R4]
				end
				`BST_ACTIVE, `BST_READ, `BST_WRITE: begin
					if (is_rd || is_wr) begin
						// fresh burst, ap by bit ten [R5] [R6] [R23]
						bl_d = 1'b1;
						bb_d = p_ba;
						if (p_a10 && is_rd) begin
							st_d[p_ba] = `BST_READ_AP;
							ld[p_ba]   = 1'b1;
							ldv[p_ba]  = T_RP; // [R15]
						end else if (p_a10) begin
							st_d[p_ba] = `BST_WRITE_AP;
							ld[p_ba]   = 1'b1;
							ldv[p_ba]  = T_RP; // [R15]
						end else if (is_rd)
							st_d[p_ba] = `BST_READ;
						else
							st_d[p_ba] = `BST_WRITE;
					end else if (is_pre) begin
						// cut the burst, start precharge [R7] [R13]
						st_d[p_ba] = `BST_PRECH;
						ld[p_ba]   = 1'b1;
						ldv[p_ba]  = T_RP;
						if (bb_q == p_ba)
							bl_d = 1'b0;
					end else
						ill_d = 1'b1;
				end
				default: ill_d = 1'b1; // busy bank must not be hit [R12]
				endcase
			end
		end
		`DST_REFRESH, `DST_MODE, `DST_PREALL: begin
			// only inhibit or nop allowed here [R16]
			if (valid && p_cmd != `CMD_NOP)
				ill_d = 1'b1;
			if (d_done) begin
				dst_d = `DST_NORMAL; // [R17] [R18] [R19]
				for (i = 0; i < NB; i = i + 1)
					st_d[i] = `BST_IDLE;
			end
		end
		default: dst_d = `DST_NORMAL;
		endcase
	end

	// device state and burst bookkeeping
	always @(posedge ref_clk) begin
		if (srst) begin
			dst_q <= `DST_NORMAL;
			bl_q  <= 1'b0;
			bb_q  <= {BAW{1'b0}};
		end else begin
			dst_q <= dst_d;
			bl_q  <= bl_d;
			bb_q  <= bb_d;
		end
	end

	// per-bank state registers
	always @(posedge ref_clk) begin
		if (srst) begin
			for (j = 0; j < NB; j = j + 1)
				st_q[j] <= `BST_IDLE;
		end else begin
			for (j = 0; j < NB; j = j + 1)
				st_q[j] <= st_d[j];
		end
	end

	// flattened bank states, straight from flops
	always @(posedge ref_clk) begin
		if (srst) begin
			bank_state <= {(3*NB){1'b0}};
		end else begin
			for (m = 0; m < NB; m = m + 1)
				bank_state[3*m +: 3] <= st_d[m];
		end
	end

	// all idle needs the normal device state and every bank idle [R10]
	always @* begin
		idle_nx = (dst_d == `DST_NORMAL);
		for (k = 0; k < NB; k = k + 1)
			if (st_d[k] != `BST_IDLE)
				idle_nx = 1'b0;
	end

	// registered idle level for the controller
	always @(posedge ref_clk) begin
		if (srst)
			all_idle <= 1'b1;
		else
			all_idle <= idle_nx;
	end

	// device state mirror
	always @(posedge ref_clk) begin
		if (srst)
			dev_state <= `DST_NORMAL;
		else
			dev_state <= dst_d;
	end

	// terminable burst flag [R8]
	always @(posedge ref_clk) begin
		if (srst)
			burst_live <= 1'b0;
		else
			burst_live <= bl_d;
	end

	// bank of the most recent burst [R8]
	always @(posedge ref_clk) begin
		if (srst)
			burst_bank <= {BAW{1'b0}};
		else
			burst_bank <= bb_d;
	end

	// one cycle pulse per unsupported pair [R22]; precharge all is not flagged in the normal device state, whatever the bank states [R20]
	always @(posedge ref_clk) begin
		if (srst)
			cmd_illegal <= 1'b0;
		else
			cmd_illegal <= ill_d;
	end
endmodule // sdram_bank_fsm
